// *** rtl/exec_cfg.svh ***
// Opcode, timing, flag layout and address constants of the execution slice
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH
`define B1_MULDIV 8'h05
`define B1_INC_MEM 8'h26
`define B1_DEC_MEM 8'h27
`define B1_ROT_R 8'h30
`define B1_ROT_L 8'h31
`define B1_BCD_ADD 8'h0e
`define B1_BCD_SUB 8'h0f
`define B1_BIT_MEM 8'h08
`define B1_BIT_AX 8'h03
`define B1_BIT_PSW 8'h02
`define B1_PAIR_HI 4'h4
`define B2_MUL 5'h00
`define B2_DIV 5'h03
`define B2_NRR 7'h44
`define B2_NRL 7'h4d
`define CLK_MUL 7'h2b
`define CLK_DIV 7'h47
`define CLK_INC_MEM 7'h02
`define CLK_PAIR 7'h03
`define CLK_SHIFT_BASE 7'h03
`define CLK_STEP_BYTE 7'h02
`define CLK_STEP_WORD 7'h03
`define CLK_NRR 7'h16
`define CLK_NRL 7'h17
`define CLK_BCD 7'h03
`define CLK_BIT 7'h05
`define CLK_BIT_STORE 7'h08
`define CLK_PSW_STORE 7'h07
`define CLK_BAD 7'h01
`define MUL_STEPS 5'h08
`define DIV_STEPS 5'h10
`define PSW_Z 3'h6
`define PSW_AC 3'h4
`define PSW_CY 3'h0
`define HIGH_PAGE 16'hfe00
`define SADDR_PAGE 16'hfe00
`define REG_X 3'h0
`define REG_A 3'h1
`endif

// *** rtl/exec_pkg.sv ***
// Types shared by the execution slice
`default_nettype none
package exec_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'b0000, OP_MUL = 4'b0001, OP_DIV = 4'b0010, OP_INC_M = 4'b0011,
    OP_DEC_M = 4'b0100, OP_PAIR_ADD_ONE_OP = 4'b0101, OP_PAIR_SUB_ONE_OP = 4'b0110, OP_ROT8 = 4'b0111,
    OP_ROT16 = 4'b1000, OP_NRR = 4'b1001, OP_NRL = 4'b1010, OP_BCDA = 4'b1011,
    OP_BCDS = 4'b1100, OP_BLD = 4'b1101, OP_BST = 4'b1110, OP_BAND = 4'b1111
  } op_kind_t;
  typedef enum logic [1:0] {
    TGT_MEM = 2'b00, TGT_A = 2'b01, TGT_X = 2'b10, TGT_PSW = 2'b11
  } tgt_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_RUN = 1'b1} run_st_t;
  typedef struct packed {
    run_st_t st;
    op_kind_t op;
    logic [6:0] cnt;
    logic [6:0] run;
    logic [2:0] steps;
    tgt_t tgt;
    logic [2:0] bsel;
    logic inv;
    logic [2:0] rsel;
    logic [1:0] psel;
    logic [15:0] addr;
    logic [15:0] ax;
    logic [7:0] rv;
    logic [15:0] pv;
    logic [7:0] mv;
    logic [7:0] program_status_word;
    logic [7:0] src;
    logic cy0;
    logic bad;
  } core_st_t;
  typedef struct packed {
    logic busy;
    logic done;
    logic div;
    logic [4:0] cnt;
    logic [23:0] p;
    logic [15:0] a;
    logic [7:0] b;
    logic [8:0] rem;
  } mdu_st_t;
endpackage
`default_nettype wire

// *** rtl/exec_if.sv ***
// Bundle between the core sequencer, multiply/divide unit and decimal adjuster
`timescale 1ns/1ns
`default_nettype none
interface exec_if;
  logic ce;
  logic start;
  logic is_div;
  logic [15:0] dvd;
  logic [7:0] dvs;
  logic done;
  logic [15:0] hi;
  logic [7:0] lo;
  logic bcd_sub;
  logic [7:0] bcd_a;
  logic bcd_ac;
  logic bcd_cy;
  logic [7:0] bcd_res;
  logic bcd_ac_o;
  logic bcd_cy_o;
  modport core(output ce, start, is_div, dvd, dvs, bcd_sub, bcd_a, bcd_ac, bcd_cy,
    input done, hi, lo, bcd_res, bcd_ac_o, bcd_cy_o);
  modport mdu(input ce, start, is_div, dvd, dvs, output done, hi, lo);
  modport bcd(input bcd_sub, bcd_a, bcd_ac, bcd_cy, output bcd_res, bcd_ac_o, bcd_cy_o);
endinterface // exec_if
`default_nettype wire

// *** rtl/muldiv_unit.sv ***
// Iterative 16x8 multiplier and 16/8 restoring divider
`timescale 1ns/1ns
`default_nettype none
`include "exec_cfg.svh"
module muldiv_unit import exec_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Core side
  exec_if.mdu lnk
);
  mdu_st_t r, n;
  logic [16:0] sum;
  logic [8:0] trial;
  logic fits;

  always_comb begin
    n = r;
    n.done = 1'b0;
    sum = {1'b0, r.p[23:8]} + (r.p[0] ? {1'b0, r.a} : 17'h0_0000);
    trial = {r.rem[7:0], r.p[15]};
    fits = trial >= {1'b0, r.b};
    if (lnk.start) begin
      n.busy = 1'b1;
      n.div = lnk.is_div;
      n.cnt = lnk.is_div ? `DIV_STEPS : `MUL_STEPS;
      n.a = lnk.dvd;
      n.b = lnk.dvs;
      n.rem = 9'h000;
      n.p = lnk.is_div ? {8'h00, lnk.dvd} : {16'h0000, lnk.dvs};
    end else if (r.busy) begin
      if (r.div) begin
        // Quotient bits shift into the low end
        n.p = {8'h00, r.p[14:0], fits};
        n.rem = fits ? trial - {1'b0, r.b} : trial;
      end else begin
        // Shift-add on the multiplier held in the low byte
        n.p = {sum, r.p[7:1]};
      end
      n.cnt = r.cnt - 5'h01;
      if (r.cnt == 5'h01) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else if (lnk.ce) begin
      r <= n;
    end
  end

  assign lnk.done = r.done;
  assign lnk.hi = r.div ? r.p[15:0] : r.p[23:8];
  assign lnk.lo = r.div ? r.rem[7:0] : r.p[7:0];

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_mul_product: assert property (r.done && !r.div |->
    r.p == 24'(r.a) * 24'(r.b)) else $error("product wrong");
  chk_div_identity: assert property (r.done && r.div && r.b != 8'h00 |->
    24'(r.p[15:0]) * 24'(r.b) + 24'(r.rem) == 24'(r.a) && r.rem < 9'(r.b))
    else $error("quotient or remainder wrong");
endmodule // muldiv_unit
`default_nettype wire

// *** rtl/bcd_adjust.sv ***
// Packed BCD correction of the accumulator after add or subtract
`timescale 1ns/1ns
`default_nettype none
module bcd_adjust (
  // Core side
  exec_if.bcd lnk
);
  logic lo_fix;
  logic hi_fix;

  // Correction factors follow the half and full carries
  always_comb begin
    if (lnk.bcd_sub) begin
      lo_fix = lnk.bcd_ac;
      hi_fix = lnk.bcd_cy;
      lnk.bcd_res = lnk.bcd_a - (lo_fix ? 8'h06 : 8'h00) - (hi_fix ? 8'h60 : 8'h00);
      lnk.bcd_ac_o = lo_fix;
    end else begin
      lo_fix = lnk.bcd_ac || (lnk.bcd_a[3:0] > 4'h9);
      hi_fix = lnk.bcd_cy || (lnk.bcd_a > 8'h99);
      lnk.bcd_res = lnk.bcd_a + (lo_fix ? 8'h06 : 8'h00) + (hi_fix ? 8'h60 : 8'h00);
      lnk.bcd_ac_o = lnk.bcd_a[3:0] > 4'h9;
    end
    lnk.bcd_cy_o = hi_fix;
  end
endmodule // bcd_adjust
`default_nettype wire

// *** rtl/mul_shift_bit_execute.sv ***
// Execution slice: multiply/divide, inc/dec, shifts, nibble rotate, BCD, carry bit ops
// Function
// - Multiply word accumulator by register; high 16 bits to accumulator, 43 clocks
// - Divide word accumulator by register; quotient, remainder back, 71 clocks
// - Add one to short-direct byte, written back in 2 clocks
// - Subtract one from short-direct byte, written back
// - Pair add/subtract one, bit 3 picks subtract, 3 clocks
// - Rotate right n times, bit 0 into carry and bit 7, 3+2n clocks
// - Rotate left n times, bit 7 into carry and bit 0
// - Rotate right through carry n times
// - Rotate left through carry n times
// - Byte shift right, zero fill, clears auxiliary carry
// - Byte shift left, bit 7 to carry, zero fill
// - Pair shift right, zero into bit 15, 3+3n clocks
// - Pair shift left, bit 15 to carry, zero fill, n up to 7
// - Nibble rotate right on high-page byte with accumulator, 22 clocks
// - Nibble rotate left on high-page byte with accumulator, 23 clocks
// - Decimal adjust after add or subtract, 3 clocks, updates carries
// - Carry loaded from chosen short-direct bit in 5 clocks
// - Carry stored to short-direct bit, other bits and flags kept, 8 clocks
// - Carry stored to status word bit in 7 clocks
// - Carry ANDed with true or complemented short-direct bit
// - Accumulator/X bit ops; complemented AND forms take 5 clocks
`timescale 1ns/1ns
`default_nettype none
`include "exec_cfg.svh"
module mul_shift_bit_execute import exec_pkg::*; (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // Instruction from the sequencer
  input wire logic op_valid,
  output logic op_ready,
  input wire logic [7:0] op_b1,
  input wire logic [7:0] op_b2,
  input wire logic [7:0] op_b3,
  // Operands, valid with op_valid
  input wire logic [7:0] acc_in,
  input wire logic [7:0] x_in,
  input wire logic [15:0] ax_in,
  input wire logic [7:0] reg_in,
  input wire logic [15:0] pair_in,
  input wire logic [7:0] mem_in,
  input wire logic [7:0] psw_in,
  // Completion
  output logic busy,
  output logic done,
  output logic bad_op,
  // Write-back
  output logic wr_ax,
  output logic [15:0] ax_out,
  output logic wr_reg,
  output logic [2:0] reg_sel,
  output logic [7:0] reg_out,
  output logic wr_pair,
  output logic [1:0] pair_sel,
  output logic [15:0] pair_out,
  output logic wr_mem,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_out,
  output logic wr_psw,
  output logic [7:0] psw_out
);
  core_st_t r, n;
  exec_if lnk();
  op_kind_t dec_op;
  tgt_t tgt;
  logic accept;
  logic [7:0] srcb;
  logic [7:0] wv;
  logic sbit;
  logic [16:0] sh;

  function automatic op_kind_t decode(input logic [7:0] b1, input logic [7:0] b2);
    case (b1)
      `B1_MULDIV: begin
        if (b2[7:3] == `B2_MUL) decode = OP_MUL;
        else if (b2[7:3] == `B2_DIV) decode = OP_DIV;
        else if ({b2[7:2], b2[0]} == `B2_NRR) decode = OP_NRR;
        else if ({b2[7:2], b2[0]} == `B2_NRL) decode = OP_NRL;
        else decode = OP_NONE;
      end
      `B1_INC_MEM: decode = OP_INC_M;
      `B1_DEC_MEM: decode = OP_DEC_M;
      `B1_ROT_R, `B1_ROT_L: decode = (b2[7:6] == 2'b11) ? OP_ROT16 : OP_ROT8;
      `B1_BCD_ADD: decode = OP_BCDA;
      `B1_BCD_SUB: decode = OP_BCDS;
      `B1_BIT_MEM, `B1_BIT_AX, `B1_BIT_PSW: begin
        // Special-function-register forms belong to another slice
        if (b2[7:6] != 2'b00 || (b1 == `B1_BIT_MEM && b2[3])) decode = OP_NONE;
        else if (b2[5:4] == 2'b00) decode = OP_BLD;
        else if (b2[5:4] == 2'b01) decode = OP_BST;
        else decode = OP_BAND;
      end
      default: begin
        // Bit 3 of the pair opcode selects subtract
        if (b1[7:4] == `B1_PAIR_HI && b1[2]) decode = b1[3] ? OP_PAIR_SUB_ONE_OP : OP_PAIR_ADD_ONE_OP;
        else decode = OP_NONE;
      end
    endcase
  endfunction

  // One step per count; the count is used as is, so zero is a no-op
  function automatic logic [16:0] shift_n(input logic [15:0] v_in, input logic wide,
      input logic left, input logic [1:0] kind, input logic [2:0] cnt, input logic cy_in);
    logic [15:0] v;
    logic cy;
    logic fill;
    v = v_in;
    cy = cy_in;
    fill = 1'b0;
    for (int i = 0; i < 7; i++) begin
      if (3'(i) < cnt) begin
        if (wide) begin
          // Zero fill on both ends of the pair
          cy = left ? v[15] : v[0];
          v = left ? {v[14:0], 1'b0} : {1'b0, v[15:1]};
        end else begin
          case (kind)
            2'b01: fill = left ? v[7] : v[0];
            2'b00: fill = cy;
            default: fill = 1'b0;
          endcase
          cy = left ? v[7] : v[0];
          v = left ? {8'h00, v[6:0], fill} : {8'h00, fill, v[7:1]};
        end
      end
    end
    shift_n = {cy, v};
  endfunction

  function automatic logic [6:0] clocks_of(input op_kind_t op, input tgt_t t,
      input logic [2:0] cnt);
    case (op)
      OP_MUL: clocks_of = `CLK_MUL;
      OP_DIV: clocks_of = `CLK_DIV;
      OP_INC_M, OP_DEC_M: clocks_of = `CLK_INC_MEM;
      OP_PAIR_ADD_ONE_OP, OP_PAIR_SUB_ONE_OP: clocks_of = `CLK_PAIR;
      OP_ROT8: clocks_of = `CLK_SHIFT_BASE + `CLK_STEP_BYTE * {4'h0, cnt};
      OP_ROT16: clocks_of = `CLK_SHIFT_BASE + `CLK_STEP_WORD * {4'h0, cnt};
      OP_NRR: clocks_of = `CLK_NRR;
      OP_NRL: clocks_of = `CLK_NRL;
      OP_BCDA, OP_BCDS: clocks_of = `CLK_BCD;
      OP_BLD, OP_BAND: clocks_of = `CLK_BIT;
      OP_BST: clocks_of = (t == TGT_PSW) ? `CLK_PSW_STORE : `CLK_BIT_STORE;
      default: clocks_of = `CLK_BAD;
    endcase
  endfunction

  muldiv_unit u_mdu (
    .mclk(mclk),
    .srst(srst),
    .lnk(lnk.mdu)
  );

  bcd_adjust u_bcd (
    .lnk(lnk.bcd)
  );

  assign op_ready = r.st == ST_IDLE;
  assign accept = ce && op_valid && op_ready;
  assign dec_op = decode(op_b1, op_b2);
  assign lnk.ce = ce;
  assign lnk.start = accept && (dec_op == OP_MUL || dec_op == OP_DIV);
  assign lnk.is_div = dec_op == OP_DIV;
  assign lnk.dvd = ax_in;
  assign lnk.dvs = reg_in;
  assign lnk.bcd_sub = op_b1[0];
  assign lnk.bcd_a = acc_in;
  assign lnk.bcd_ac = psw_in[`PSW_AC];
  assign lnk.bcd_cy = psw_in[`PSW_CY];

  always_comb begin
    n = r;
    if (op_b1 == `B1_BIT_PSW) tgt = TGT_PSW;
    else if (op_b1 == `B1_BIT_AX) tgt = op_b2[3] ? TGT_A : TGT_X;
    else tgt = TGT_MEM;
    case (tgt)
      TGT_A: srcb = acc_in;
      TGT_X: srcb = x_in;
      TGT_PSW: srcb = psw_in;
      default: srcb = mem_in;
    endcase
    sbit = srcb[op_b2[2:0]] ^ (dec_op == OP_BAND && op_b2[4]);
    wv = srcb;
    wv[op_b2[2:0]] = psw_in[`PSW_CY];
    sh = shift_n(op_b2[7:6] == 2'b11 ? pair_in : {8'h00, reg_in}, op_b2[7:6] == 2'b11,
      op_b1[0], op_b2[7:6], op_b2[5:3], psw_in[`PSW_CY]);
    if (accept) begin
      n.st = ST_RUN;
      n.op = dec_op;
      n.cnt = clocks_of(dec_op, tgt, op_b2[5:3]);
      n.run = 7'h01;
      n.steps = op_b2[5:3];
      n.tgt = tgt;
      n.bsel = op_b2[2:0];
      n.inv = dec_op == OP_BAND && op_b2[4];
      n.rsel = op_b2[2:0];
      n.psel = (dec_op == OP_ROT16) ? op_b2[2:1] : op_b1[1:0];
      n.addr = `SADDR_PAGE + {8'h00, op_b2};
      n.program_status_word = psw_in;
      n.src = srcb;
      n.cy0 = psw_in[`PSW_CY];
      n.bad = dec_op == OP_NONE;
      case (dec_op)
        OP_INC_M, OP_DEC_M: begin
          n.mv = op_b1[0] ? mem_in - 8'h01 : mem_in + 8'h01;
          n.program_status_word[`PSW_Z] = n.mv == 8'h00;
          n.program_status_word[`PSW_AC] = op_b1[0] ? mem_in[3:0] == 4'h0 : mem_in[3:0] == 4'hf;
        end
        OP_PAIR_ADD_ONE_OP: n.pv = pair_in + 16'h0001;
        OP_PAIR_SUB_ONE_OP: n.pv = pair_in - 16'h0001;
        OP_ROT8, OP_ROT16: begin
          n.rv = sh[7:0];
          n.pv = sh[15:0];
          n.program_status_word[`PSW_CY] = sh[16];
          if (op_b2[7] && op_b2[5:3] != 3'h0) begin
            n.program_status_word[`PSW_Z] = op_b2[6] ? sh[15:0] == 16'h0000 : sh[7:0] == 8'h00;
            n.program_status_word[`PSW_AC] = 1'b0;
          end
        end
        OP_NRR, OP_NRL: begin
          n.addr = `HIGH_PAGE + {8'h00, reg_in};
          n.rsel = `REG_A;
          n.src = mem_in;
          n.rv = {acc_in[7:4], op_b2[0] ? mem_in[7:4] : mem_in[3:0]};
          n.mv = op_b2[0] ? {mem_in[3:0], acc_in[3:0]} : {acc_in[3:0], mem_in[7:4]};
        end
        OP_BCDA, OP_BCDS: begin
          n.rsel = `REG_A;
          n.rv = lnk.bcd_res;
          n.program_status_word[`PSW_Z] = lnk.bcd_res == 8'h00;
          n.program_status_word[`PSW_AC] = lnk.bcd_ac_o;
          n.program_status_word[`PSW_CY] = lnk.bcd_cy_o;
        end
        OP_BLD: n.program_status_word[`PSW_CY] = sbit;
        OP_BAND: n.program_status_word[`PSW_CY] = psw_in[`PSW_CY] & sbit;
        OP_BST: begin
          n.addr = `SADDR_PAGE + {8'h00, op_b3};
          n.mv = wv;
          n.rv = wv;
          n.rsel = (tgt == TGT_A) ? `REG_A : `REG_X;
          // Whole status word rewritten; only the chosen bit takes CY, so Z may change but CY cannot
          if (tgt == TGT_PSW) n.program_status_word = wv;
        end
        default: n.bad = dec_op == OP_NONE;
      endcase
      if (dec_op == OP_BLD || dec_op == OP_BAND) n.addr = `SADDR_PAGE + {8'h00, op_b3};
    end else if (r.st == ST_RUN) begin
      n.run = r.run + 7'h01;
      n.cnt = r.cnt - 7'h01;
      if (r.cnt == 7'h01) n.st = ST_IDLE;
      if (lnk.done) begin
        n.ax = lnk.hi;
        n.rv = lnk.lo;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign busy = r.st == ST_RUN;
  assign done = ce && r.st == ST_RUN && r.cnt == 7'h01;
  assign bad_op = done && r.bad;
  assign ax_out = r.ax;
  assign reg_sel = r.rsel;
  assign reg_out = r.rv;
  assign pair_sel = r.psel;
  assign pair_out = r.pv;
  assign mem_addr = r.addr;
  assign mem_out = r.mv;
  assign psw_out = r.program_status_word;

  // Strobes only in the last counted cycle, so the sequencer sees the documented length
  always_comb begin
    wr_ax = 1'b0;
    wr_reg = 1'b0;
    wr_pair = 1'b0;
    wr_mem = 1'b0;
    wr_psw = 1'b0;
    case (r.op)
      OP_MUL, OP_DIV: begin
        wr_ax = done;
        wr_reg = done;
      end
      OP_INC_M, OP_DEC_M: begin
        wr_mem = done;
        wr_psw = done;
      end
      OP_PAIR_ADD_ONE_OP, OP_PAIR_SUB_ONE_OP: wr_pair = done;
      OP_ROT8: begin
        wr_reg = done;
        wr_psw = done;
      end
      OP_ROT16: begin
        wr_pair = done;
        wr_psw = done;
      end
      OP_NRR, OP_NRL: begin
        wr_reg = done;
        wr_mem = done;
      end
      OP_BCDA, OP_BCDS: begin
        wr_reg = done;
        wr_psw = done;
      end
      OP_BLD, OP_BAND: wr_psw = done;
      OP_BST: begin
        wr_mem = done && r.tgt == TGT_MEM;
        wr_reg = done && (r.tgt == TGT_A || r.tgt == TGT_X);
        wr_psw = done && r.tgt == TGT_PSW;
      end
      default: wr_ax = 1'b0;
    endcase
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  chk_mul_clocks: assert property (done && r.op == OP_MUL |-> r.run == 7'd43 && wr_ax)
    else $error("multiply length wrong");
  chk_div_clocks: assert property (done && r.op == OP_DIV |-> r.run == 7'd71)
    else $error("divide length wrong");
  chk_inc_mem: assert property (done && r.op == OP_INC_M |->
    r.run == 7'd2 && mem_out == r.src + 8'h01 && wr_mem) else $error("increment wrong");
  chk_dec_mem: assert property (done && r.op == OP_DEC_M |->
    mem_out == r.src - 8'h01) else $error("decrement wrong");
  chk_pair_clocks: assert property (done && (r.op == OP_PAIR_ADD_ONE_OP || r.op == OP_PAIR_SUB_ONE_OP) |->
    r.run == 7'd3 && wr_pair) else $error("pair step length wrong");
  chk_rot_clocks: assert property (done && r.op == OP_ROT8 |->
    r.run == 7'd3 + 7'd2 * {4'h0, r.steps}) else $error("byte shift length wrong");
  chk_word_clocks: assert property (done && r.op == OP_ROT16 |->
    r.run == 7'd3 + 7'd3 * {4'h0, r.steps}) else $error("pair shift length wrong");
  chk_nib_clocks: assert property (done && (r.op == OP_NRR || r.op == OP_NRL) |->
    r.run == (r.op == OP_NRR ? 7'd22 : 7'd23)) else $error("nibble rotate length wrong");
  chk_bcd_clocks: assert property (done && r.op == OP_BCDA |-> r.run == 7'd3)
    else $error("decimal adjust length wrong");
  chk_bst_keep: assert property (wr_mem && r.op == OP_BST |->
    ((mem_out ^ r.src) & ~(8'h01 << r.bsel)) == 8'h00 && r.run == 7'd8 && !wr_psw)
    else $error("bit store disturbed other bits");
  chk_psw_store: assert property (wr_psw && r.op == OP_BST |-> r.run == 7'd7)
    else $error("status bit store length wrong");
  chk_band_cy: assert property (done && r.op == OP_BAND |->
    psw_out[0] == (r.cy0 & (r.src[r.bsel] ^ r.inv)) && r.run == 7'd5)
    else $error("bit AND result wrong");
  chk_busy_hold: assert property (accept |=> busy && !op_ready)
    else $error("second instruction taken while busy");
  cov_mul: cover property (done && r.op == OP_MUL);
  cov_rot7: cover property (done && r.op == OP_ROT8 && r.steps == 3'h7);
  cov_psw_store: cover property (done && r.op == OP_BST && r.tgt == TGT_PSW);
  cov_freeze: cover property (busy && !ce);
endmodule // mul_shift_bit_execute
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the execution slice
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic op_valid = 1'b0;
  logic [7:0] op_b1 = 8'h00, op_b2 = 8'h00, op_b3 = 8'h00, acc_in = 8'h00, x_in = 8'h00;
  logic [7:0] reg_in = 8'h00, mem_in = 8'h00, psw_in = 8'h00;
  logic [15:0] ax_in = 16'h0000, pair_in = 16'h0000;
  logic op_ready, busy, done, bad_op, wr_ax, wr_reg, wr_pair, wr_mem, wr_psw;
  logic [15:0] ax_out, pair_out, mem_addr;
  logic [2:0] reg_sel;
  logic [1:0] pair_sel;
  logic [7:0] reg_out, mem_out, psw_out;
  int errors = 0;
  int checked = 0;

  always #50 mclk = ~mclk;

  mul_shift_bit_execute mul_shift_bit_execute_inst (
    .mclk(mclk), .srst(srst), .ce(ce), .op_valid(op_valid), .op_ready(op_ready),
    .op_b1(op_b1), .op_b2(op_b2), .op_b3(op_b3), .acc_in(acc_in), .x_in(x_in),
    .ax_in(ax_in), .reg_in(reg_in), .pair_in(pair_in), .mem_in(mem_in), .psw_in(psw_in),
    .busy(busy), .done(done), .bad_op(bad_op), .wr_ax(wr_ax), .ax_out(ax_out),
    .wr_reg(wr_reg), .reg_sel(reg_sel), .reg_out(reg_out), .wr_pair(wr_pair),
    .pair_sel(pair_sel), .pair_out(pair_out), .wr_mem(wr_mem), .mem_addr(mem_addr),
    .mem_out(mem_out), .wr_psw(wr_psw), .psw_out(psw_out)
  );

  task automatic tally_and_finish;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Offer one op, count counted cycles up to done; hold keeps offering while busy
  task automatic run_op(input logic [7:0] b1, b2, b3, input int n, input bit hold, stall);
    int cnt = 0;
    // Ready is still low in the done cycle; offer only once idle
    while (op_ready !== 1'b1 && cnt < 4) begin
      @(negedge mclk);
      cnt++;
    end
    op_b1 = b1;
    op_b2 = b2;
    op_b3 = b3;
    op_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    if (!hold) op_valid = 1'b0;
    cnt = 1;
    while (done !== 1'b1) begin
      if (cnt == 2) chk(op_ready, 1'b0);
      // Frozen cycles must not count toward the total
      if (stall && cnt == 2) begin
        ce = 1'b0;
        repeat (5) @(negedge mclk);
        chk(busy, 1'b1);
        ce = 1'b1;
      end
      if (hold && cnt == n - 1) op_valid = 1'b0;
      if (cnt > 300) begin
        errors++;
        tally_and_finish();
      end
      @(negedge mclk);
      cnt++;
    end
    chk(cnt, n);
  endtask

  function automatic logic [16:0] shift_ref(input logic [15:0] v, input int k, d, n,
      input logic cy);
    logic c, f;
    for (int i = 0; i < n; i++) begin
      if (k == 3) begin
        c = d ? v[15] : v[0];
        v = d ? v << 1 : v >> 1;
      end else begin
        c = d ? v[7] : v[0];
        f = (k == 1) ? c : (k == 0) ? cy : 1'b0;
        v[7:0] = d ? {v[6:0], f} : {f, v[7:1]};
      end
      cy = c;
    end
    return {cy, v};
  endfunction

  task automatic t_muldiv;
    logic [23:0] p;
    ax_in = 16'h1234;
    reg_in = 8'h56;
    p = 24'(ax_in) * 24'(reg_in);
    run_op(8'h05, 8'h03, 8'h00, 43, 1'b1, 1'b0);
    chk({ax_out, reg_out}, p);
    chk({wr_ax, wr_reg, reg_sel}, 5'h1b);
    ax_in = 16'h03e8;
    reg_in = 8'h07;
    run_op(8'h05, 8'h1a, 8'h00, 71, 1'b0, 1'b1);
    chk({ax_out, reg_out}, {ax_in / 16'h0007, 8'(ax_in % 16'h0007)});
  endtask

  task automatic t_incdec;
    mem_in = 8'hff;
    run_op(8'h26, 8'h9c, 8'h00, 2, 1'b0, 1'b0);
    chk({wr_mem, mem_addr, mem_out}, 25'h1fe_9c00);
    mem_in = 8'h00;
    run_op(8'h27, 8'h10, 8'h00, 2, 1'b0, 1'b0);
    chk({mem_addr, mem_out}, 24'hfe10ff);
    pair_in = 16'h00ff;
    run_op(8'h46, 8'h00, 8'h00, 3, 1'b0, 1'b0);
    chk({wr_pair, pair_sel, pair_out}, 19'h6_0100);
    pair_in = 16'h0000;
    run_op(8'h4f, 8'h00, 8'h00, 3, 1'b0, 1'b0);
    chk({pair_sel, pair_out}, 18'h3_ffff);
  endtask

  task automatic t_shift;
    logic [16:0] e;
    int n;
    reg_in = 8'hb4;
    pair_in = 16'h8ab3;
    psw_in = 8'h11;
    for (int k = 0; k < 4; k++) begin
      for (int d = 0; d < 2; d++) begin
        for (int j = 0; j < 3; j++) begin
          n = 3 * j + j / 2;
          e = shift_ref((k == 3) ? pair_in : {8'h00, reg_in}, k, d, n, psw_in[0]);
          run_op(8'h30 + 8'(d), {2'(k), 3'(n), 3'h2}, 8'h00, (k == 3) ? 3 + 3 * n : 3 + 2 * n,
            1'b0, 1'b0);
          if (k == 3) chk(pair_out, e[15:0]);
          else chk(reg_out, e[7:0]);
          chk(psw_out[0], e[16]);
          if (n == 0) chk(psw_out, psw_in);
          else if (k >= 2) chk(psw_out[4], 1'b0);
        end
      end
    end
  endtask

  task automatic t_nibble;
    acc_in = 8'ha5;
    mem_in = 8'h3c;
    reg_in = 8'h40;
    run_op(8'h05, 8'h88, 8'h00, 22, 1'b0, 1'b0);
    chk({mem_addr, mem_out}, 24'hfe40_53);
    chk({wr_reg, reg_out[3:0]}, 5'h1c);
    run_op(8'h05, 8'h99, 8'h00, 23, 1'b0, 1'b0);
    chk(mem_out, 8'hc5);
    chk({wr_reg, reg_out[3:0]}, 5'h13);
  endtask

  task automatic t_bcd_bad;
    acc_in = 8'h9a;
    psw_in = 8'h00;
    run_op(8'h0e, 8'h00, 8'h00, 3, 1'b0, 1'b0);
    chk({psw_out[6], psw_out[0]}, 2'h3);
    chk({wr_reg, reg_out}, 9'h100);
    acc_in = 8'h1e;
    psw_in = 8'h10;
    run_op(8'h0f, 8'h00, 8'h00, 3, 1'b0, 1'b0);
    chk(psw_out[0], 1'b0);
    chk({wr_reg, reg_out}, 9'h118);
    run_op(8'hff, 8'h00, 8'h00, 1, 1'b0, 1'b0);
    chk(bad_op, 1'b1);
  endtask

  task automatic t_bits;
    mem_in = 8'h20;
    psw_in = 8'h00;
    run_op(8'h08, 8'h05, 8'h30, 5, 1'b0, 1'b0);
    chk(psw_out[0], 1'b1);
    psw_in = 8'h01;
    run_op(8'h08, 8'h35, 8'h30, 5, 1'b0, 1'b0);
    chk(psw_out[0], 1'b0);
    acc_in = 8'h04;
    run_op(8'h03, 8'h2a, 8'h00, 5, 1'b0, 1'b0);
    chk(psw_out[0], 1'b1);
    run_op(8'h03, 8'h3a, 8'h00, 5, 1'b0, 1'b0);
    chk(psw_out[0], 1'b0);
    mem_in = 8'h00;
    run_op(8'h08, 8'h13, 8'h44, 8, 1'b0, 1'b0);
    chk({wr_mem, mem_addr, mem_out}, 25'h1fe_4408);
    chk({wr_psw, psw_out}, {1'b0, psw_in});
    psw_in = 8'h41;
    run_op(8'h02, 8'h14, 8'h00, 7, 1'b0, 1'b0);
    chk({wr_psw, psw_out}, 9'h151);
    x_in = 8'h00;
    run_op(8'h03, 8'h17, 8'h00, 8, 1'b0, 1'b0);
    chk({wr_reg, reg_sel, reg_out}, 12'h880);
  endtask

  initial begin
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    chk({op_ready, busy, done}, 3'h4);
    t_muldiv();
    t_incdec();
    t_shift();
    t_nibble();
    t_bcd_bad();
    t_bits();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
